// ### eis_edge.sv
`timescale 1ns/1ps
`default_nettype none

// rising edge detector on a same-clock level
module eis_edge #(
   parameter int WIDTH = 1                          // lanes
) (
   input  wire logic             aclk,              // clock
   input  wire logic             aresetn,           // sync reset, low
   input  wire logic [WIDTH-1:0] level,             // level in
   output logic      [WIDTH-1:0] rise               // one-cycle pulse
);

   logic [WIDTH-1:0] last;

   // previous level; reset low so a level high out of reset counts once
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         last <= '0;
      else
         last <= level;
   end

   assign rise = level & ~last;

endmodule : eis_edge

`default_nettype wire

// ### eis_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host side of the register bus; ready waits high for each answer
module eis_host_model (
   input  wire logic        aclk,    // clock
   output logic [7:0]       awaddr,  // wr addr
   output logic             awvalid, // wr addr valid
   input  wire logic        awready, // wr addr ready
   output logic [31:0]      wdata,   // wr data
   output logic [3:0]       wstrb,   // byte lanes
   output logic             wvalid,  // wr data valid
   input  wire logic        wready,  // wr data ready
   input  wire logic [1:0]  bresp,   // wr resp
   input  wire logic        bvalid,  // wr resp valid
   output logic             bready,  // wr resp ready
   output logic [7:0]       araddr,  // rd addr
   output logic             arvalid, // rd addr valid
   input  wire logic        arready, // rd addr ready
   input  wire logic [31:0] rdata,   // rd data
   input  wire logic [1:0]  rresp,   // rd resp
   input  wire logic        rvalid,  // rd valid
   output logic             rready   // rd ready
);
   // quiet bus from time zero
   initial
   begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end

   // address and data go together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic done;
      done = 1'b0;
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) {r, done} = {bresp, 1'b1};
      end
   endtask : wr

   // address released when taken; ready held high for the answer
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      logic done;
      done = 1'b0;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) {d, r, done} = {rdata, rresp, 1'b1};
      end
   endtask : rd
endmodule : eis_host_model

`default_nettype wire

// ### eis_interrupt_status.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none

module eis_interrupt_status #(
   parameter int PIN_COUNT = 3                      // gpio event lanes
) (
   input  wire logic                 aclk,          // 25 MHz clock
   input  wire logic                 aresetn,       // sync reset, low
   // axi4-lite slave
   input  wire logic [7:0]           s_axi_awaddr,  // write address
   input  wire logic                 s_axi_awvalid, // write addr valid
   output logic                      s_axi_awready, // write addr ready
   input  wire logic [31:0]          s_axi_wdata,   // write data
   input  wire logic [3:0]           s_axi_wstrb,   // byte enables
   input  wire logic                 s_axi_wvalid,  // write data valid
   output logic                      s_axi_wready,  // write data ready
   output logic [1:0]                s_axi_bresp,   // write response
   output logic                      s_axi_bvalid,  // response valid
   input  wire logic                 s_axi_bready,  // response ready
   input  wire logic [7:0]           s_axi_araddr,  // read address
   input  wire logic                 s_axi_arvalid, // read addr valid
   output logic                      s_axi_arready, // read addr ready
   output logic [31:0]               s_axi_rdata,   // read data
   output logic [1:0]                s_axi_rresp,   // read response
   output logic                      s_axi_rvalid,  // read data valid
   input  wire logic                 s_axi_rready,  // read ready
   // event sources, same clock domain except pins with pin_sync_sel set
   input  wire logic                 tx_halted,     // transmitter idle
   input  wire logic                 rx_halted,     // receive engine halted
   input  wire logic [31:0]          drop_count,    // dropped frame count
   input  wire logic                 tx_buffer_done,// buffer loaded pulse
   input  wire logic                 tx_buffer_notify, // its notify flag
   input  wire logic                 rx_dma_done,   // dma count drained
   input  wire logic [15:0]          timer_count,   // timer value
   input  wire logic                 phy_event,     // phy irq pending
   input  wire logic                 power_event,   // power event detect
   input  wire logic                 tx_status_ovf, // status fifo ovf
   input  wire logic                 rx_oversize,   // packet over 2048 B
   input  wire logic                 rx_error,      // receiver error
   input  wire logic                 tx_error,      // transmitter error
   input  wire logic                 tx_underrun,   // tx data underrun
   input  wire logic                 tx_data_full,  // tx data fifo full
   input  wire logic                 tx_data_write, // host tx data write
   input  wire logic                 tx_space_above,// free > threshold
   input  wire logic                 tx_status_full,// tx status full
   input  wire logic                 tx_status_level, // tx status level
   input  wire logic                 frame_dropped, // frame drop pulse
   input  wire logic                 rx_data_level, // rx data level
   input  wire logic                 rx_status_full,// rx status full
   input  wire logic                 rx_status_level, // rx status level
   input  wire logic [PIN_COUNT-1:0] pin_events,    // selected gpio events
   input  wire logic [PIN_COUNT-1:0] pin_sync_sel,  // 1: pin needs sync
   // outputs
   output logic                      irq_request,   // internal irq line
   output logic                      power_irq,     // power event, no hold-off
   output logic                      wake_request,  // byte test written
   output logic                      stop_transmit  // stop-transmit control
);

   //////////////////////////////////////////////////////////////////////////
   // state

   logic [31:0]          interrupt_status;
   logic [31:0]          irq_enable;
   logic [1:0]           event_control;
   logic [31:0]          last_drop;
   logic [15:0]          last_timer;
   logic [PIN_COUNT-1:0] pin_s1;
   logic [PIN_COUNT-1:0] pin_s2;
   logic [PIN_COUNT-1:0] pin_s3;
   logic [PIN_COUNT-1:0] pin_stable;
   logic                 aw_held;
   logic                 w_held;
   logic [7:0]           aw_addr;
   logic [31:0]          w_data;
   logic [3:0]           w_strb;

   //////////////////////////////////////////////////////////////////////////
   // level sources become one-shot events so a cleared bit stays clear
   // while the condition lingers

   localparam int LEVELS = 10;
   logic [LEVELS-1:0] level_in;
   logic [LEVELS-1:0] level_rise;

   assign level_in = {event_control[eis_pkg::CTRL_SOFTWARE_IRQ_EN],
                      event_control[eis_pkg::CTRL_STOP_TRANSMIT] & tx_halted,
                      rx_halted,
                      power_event,
                      tx_space_above,
                      tx_status_full,
                      tx_status_level,
                      rx_data_level,
                      rx_status_full,
                      rx_status_level};

   eis_edge #(
      .WIDTH (LEVELS)
   ) u_level_edge (
      .aclk    (aclk),
      .aresetn (aresetn),
      .level   (level_in),
      .rise    (level_rise)
   );

   //////////////////////////////////////////////////////////////////////////
   // gpio pins: three flops, a rise counts once stages two and three agree

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_s1     <= '0;
         pin_s2     <= '0;
         pin_s3     <= '0;
         pin_stable <= '0;
      end
      else
      begin
         pin_s1 <= pin_events;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         if (pin_s2 == pin_s3)
            pin_stable <= pin_s3;
      end
   end

   // pulses already on this clock bypass the synchroniser
   wire [PIN_COUNT-1:0] pin_hit =
      (pin_sync_sel & pin_s3 & ~pin_stable & (pin_s2 ~^ pin_s3)) |
      (~pin_sync_sel & pin_events);

   //////////////////////////////////////////////////////////////////////////
   // event vector, one bit per status position

   wire drop_mid  = (last_drop == eis_pkg::DROP_BEFORE_MID) &&
                    (drop_count == eis_pkg::DROP_AFTER_MID);
   wire timer_wrp = (last_timer == 16'h0000) &&
                    (timer_count == eis_pkg::TIMER_WRAP_VAL);

   logic [31:0] event_set;
   always_comb
   begin
      event_set = '0;
      event_set[eis_pkg::BIT_SOFTWARE_IRQ]     = level_rise[9];
      event_set[eis_pkg::BIT_TRANSMIT_HALTED]  = level_rise[8];
      event_set[eis_pkg::BIT_RECEIVE_HALTED]   = level_rise[7];
      event_set[eis_pkg::BIT_DROP_MIDPOINT]    = drop_mid;
      event_set[eis_pkg::BIT_TX_BUFFER_DONE]   =
         tx_buffer_done & tx_buffer_notify;
      event_set[eis_pkg::BIT_RX_DMA_DONE]      = rx_dma_done;
      event_set[eis_pkg::BIT_TIMER_WRAP]       = timer_wrp;
      event_set[eis_pkg::BIT_POWER_EVENT]      = level_rise[6];
      event_set[eis_pkg::BIT_TX_STATUS_OVF]    = tx_status_ovf;
      event_set[eis_pkg::BIT_RX_OVERSIZE]      = rx_oversize;
      event_set[eis_pkg::BIT_RX_ERROR]         = rx_error;
      event_set[eis_pkg::BIT_TX_ERROR]         = tx_error;
      event_set[eis_pkg::BIT_TX_DATA_UNDERRUN] = tx_underrun;
      event_set[eis_pkg::BIT_TX_DATA_OVERRUN]  =
         tx_data_full & tx_data_write;
      event_set[eis_pkg::BIT_TX_SPACE_AVAIL]   = level_rise[5];
      event_set[eis_pkg::BIT_TX_STATUS_FULL]   = level_rise[4];
      event_set[eis_pkg::BIT_TX_STATUS_LEVEL]  = level_rise[3];
      event_set[eis_pkg::BIT_FRAME_DROPPED]    = frame_dropped;
      event_set[eis_pkg::BIT_RX_DATA_LEVEL]    = level_rise[2];
      event_set[eis_pkg::BIT_RX_STATUS_FULL]   = level_rise[1];
      event_set[eis_pkg::BIT_RX_STATUS_LEVEL]  = level_rise[0];
      event_set[eis_pkg::BIT_PIN_EVENT_LSB +: PIN_COUNT] = pin_hit;
   end

   //////////////////////////////////////////////////////////////////////////
   // axi4-lite write path: address and data accepted in either order

   wire   wr_fire  = aw_held && w_held && !s_axi_bvalid;
   wire   wr_stat  = wr_fire && (aw_addr == eis_pkg::ADDR_INTERRUPT_STATUS);
   wire   wr_en    = wr_fire && (aw_addr == eis_pkg::ADDR_IRQ_ENABLE);
   wire   wr_test  = wr_fire && (aw_addr == eis_pkg::ADDR_BYTE_ORDER_TEST);
   wire   wr_ctrl  = wr_fire && (aw_addr == eis_pkg::ADDR_EVENT_CONTROL);
   wire   wr_hit   = wr_stat | wr_en | wr_test | wr_ctrl;
   wire [31:0] byte_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                            {8{w_strb[1]}}, {8{w_strb[0]}}};

   // clear mask leaves the phy bit and reserved bits 30-26 and 12 untouchable
   wire [31:0] clear_bits = wr_stat ?
      (w_data & byte_mask & eis_pkg::STATUS_CLEAR_MASK) : 32'h0;

   // set wins over clear so no event slips by
   wire [31:0] next_interrupt_status =
      (((interrupt_status & ~clear_bits) | event_set) &
       eis_pkg::STATUS_IMPL_MASK & ~(32'h1 << eis_pkg::BIT_PHY_EVENT)) |
      ({31'h0, phy_event} << eis_pkg::BIT_PHY_EVENT);

   wire [31:0] next_irq_enable =
      (irq_enable & ~byte_mask) | (w_data & byte_mask);

   // stop bit as it stands after this edge, for the registered output
   wire next_ctrl_stop = (wr_ctrl && w_strb[0]) ?
      w_data[eis_pkg::CTRL_STOP_TRANSMIT] :
      event_control[eis_pkg::CTRL_STOP_TRANSMIT];

   // status latches every masked bit except the phy bit, which follows phy_event
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         interrupt_status <= eis_pkg::RESET_STATUS;
      else
         interrupt_status <= next_interrupt_status;
   end

   // enable mask and event control registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_enable    <= eis_pkg::RESET_ENABLE;
         event_control <= 2'b00;
      end
      else
      begin
         if (wr_en)
            irq_enable <= next_irq_enable & eis_pkg::STATUS_IMPL_MASK;
         if (wr_ctrl && w_strb[0])
            event_control <= w_data[1:0];
      end
   end

   // address / data holding and response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h00000000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= eis_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? eis_pkg::RESP_OKAY
                                   : eis_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ready registered: one item per channel held until the write fires
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // axi4-lite read path

   wire ar_fire = s_axi_arvalid && s_axi_arready;
   wire [31:0] read_mux =
      (s_axi_araddr == eis_pkg::ADDR_INTERRUPT_STATUS) ? interrupt_status :
      (s_axi_araddr == eis_pkg::ADDR_IRQ_ENABLE)       ? irq_enable :
      (s_axi_araddr == eis_pkg::ADDR_BYTE_ORDER_TEST)  ?
         eis_pkg::BYTE_TEST_VALUE :
      (s_axi_araddr == eis_pkg::ADDR_EVENT_CONTROL)    ?
         {30'h0, event_control} :
      (s_axi_araddr == eis_pkg::ADDR_IRQ_STATE)        ?
         {31'h0, irq_request} : 32'h00000000;
   wire rd_hit =
      (s_axi_araddr == eis_pkg::ADDR_INTERRUPT_STATUS) ||
      (s_axi_araddr == eis_pkg::ADDR_IRQ_ENABLE) ||
      (s_axi_araddr == eis_pkg::ADDR_BYTE_ORDER_TEST) ||
      (s_axi_araddr == eis_pkg::ADDR_EVENT_CONTROL) ||
      (s_axi_araddr == eis_pkg::ADDR_IRQ_STATE);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= eis_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !ar_fire;
         if (ar_fire)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= read_mux;
            s_axi_rresp  <= rd_hit ? eis_pkg::RESP_OKAY
                                   : eis_pkg::RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // history for crossing detectors and outputs

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         last_drop  <= 32'h00000000;
         last_timer <= eis_pkg::TIMER_WRAP_VAL;
      end
      else
      begin
         last_drop  <= drop_count;
         last_timer <= timer_count;
      end
   end

   // irq follows the next status, registered on the same edge as the latch
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_request   <= 1'b0;
         power_irq     <= 1'b0;
         wake_request  <= 1'b0;
         stop_transmit <= 1'b0;
      end
      else
      begin
         irq_request   <= |(next_interrupt_status & irq_enable);
         // bypasses any hold-off stage downstream
         power_irq     <= next_interrupt_status[eis_pkg::BIT_POWER_EVENT] &
                          irq_enable[eis_pkg::BIT_POWER_EVENT];
         // only a byte test write wakes; power events never do
         wake_request  <= wr_test;
         stop_transmit <= next_ctrl_stop;
      end
   end

endmodule : eis_interrupt_status

`default_nettype wire

// ### eis_interrupt_status_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// watches the register bus and the interrupt outputs
module eis_interrupt_status_monitor (
   input wire logic        aclk,          // clock
   input wire logic        aresetn,       // reset, low
   input wire logic [7:0]  s_axi_awaddr,  // wr addr
   input wire logic        s_axi_awvalid, // wr addr valid
   input wire logic        s_axi_awready, // wr addr ready
   input wire logic [1:0]  s_axi_bresp,   // wr resp
   input wire logic        s_axi_bvalid,  // wr resp valid
   input wire logic        s_axi_bready,  // wr resp ready
   input wire logic [7:0]  s_axi_araddr,  // rd addr
   input wire logic        s_axi_arvalid, // rd addr valid
   input wire logic        s_axi_arready, // rd addr ready
   input wire logic [31:0] s_axi_rdata,   // rd data
   input wire logic [1:0]  s_axi_rresp,   // rd resp
   input wire logic        s_axi_rvalid,  // rd valid
   input wire logic        s_axi_rready,  // rd ready
   input wire logic        irq_request,   // irq line
   input wire logic        power_irq,     // power irq
   input wire logic        wake_request   // wake pulse
);
   logic [7:0] aw_q;
   logic [7:0] ar_q;
   wire        aw_ok = aw_q inside {8'h58, 8'h5C, 8'h64, 8'hC0};
   wire        ar_ok = ar_q inside {8'h58, 8'h5C, 8'h64, 8'hC0, 8'hC4};

   // the answer comes later, so hold the address from its handshake
   always_ff @(posedge aclk)
   begin
      if (s_axi_awvalid && s_axi_awready)
         aw_q <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready)
         ar_q <= s_axi_araddr;
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_write_resp_map: assert property (s_axi_bvalid |->
      s_axi_bresp == (aw_ok ? 2'h0 : 2'h2))
      else $error("write response wrong for address");
   a_byte_test_read: assert property (s_axi_rvalid && ar_q == 8'h64
      |-> s_axi_rdata == 32'h87654321)
      else $error("byte test read wrong");
   a_unmapped_read: assert property (s_axi_rvalid && !ar_ok |->
      s_axi_rdata == 32'h0 && s_axi_rresp == 2'h2)
      else $error("unmapped read not refused");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   a_wake_one_cycle: assert property (wake_request |=> !wake_request)
      else $error("wake pulse too long");
   a_wake_by_write: assert property (wake_request |-> aw_q == 8'h64)
      else $error("wake without byte test write");
   a_power_no_holdoff: assert property (power_irq |-> irq_request)
      else $error("power irq not on irq line");
endmodule : eis_interrupt_status_monitor

`default_nettype wire

// ### eis_pkg.sv
package eis_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_INTERRUPT_STATUS = 8'h58;
   localparam logic [7:0] ADDR_IRQ_ENABLE       = 8'h5C;
   localparam logic [7:0] ADDR_BYTE_ORDER_TEST  = 8'h64;
   localparam logic [7:0] ADDR_EVENT_CONTROL    = 8'hC0;
   localparam logic [7:0] ADDR_IRQ_STATE        = 8'hC4;

   // status bit positions
   localparam int BIT_SOFTWARE_IRQ      = 31;
   localparam int BIT_TRANSMIT_HALTED   = 25;
   localparam int BIT_RECEIVE_HALTED    = 24;
   localparam int BIT_DROP_MIDPOINT     = 23;
   localparam int BIT_TX_BUFFER_DONE    = 21;
   localparam int BIT_RX_DMA_DONE       = 20;
   localparam int BIT_TIMER_WRAP        = 19;
   localparam int BIT_PHY_EVENT         = 18;
   localparam int BIT_POWER_EVENT       = 17;
   localparam int BIT_TX_STATUS_OVF     = 16;
   localparam int BIT_RX_OVERSIZE       = 15;
   localparam int BIT_RX_ERROR          = 14;
   localparam int BIT_TX_ERROR          = 13;
   localparam int BIT_TX_DATA_UNDERRUN  = 11;
   localparam int BIT_TX_DATA_OVERRUN   = 10;
   localparam int BIT_TX_SPACE_AVAIL    = 9;
   localparam int BIT_TX_STATUS_FULL    = 8;
   localparam int BIT_TX_STATUS_LEVEL   = 7;
   localparam int BIT_FRAME_DROPPED     = 6;
   localparam int BIT_RX_DATA_LEVEL     = 5;
   localparam int BIT_RX_STATUS_FULL    = 4;
   localparam int BIT_RX_STATUS_LEVEL   = 3;
   localparam int BIT_PIN_EVENT_LSB     = 0;

   // implemented status bits (reserved 30-26 and 12 excluded)
   localparam logic [31:0] STATUS_IMPL_MASK  = 32'h83FFEFFF;
   // host-clearable bits: all implemented except the phy bit
   localparam logic [31:0] STATUS_CLEAR_MASK = 32'h83FBEFFF;

   localparam logic [31:0] RESET_STATUS      = 32'h00000000;
   localparam logic [31:0] RESET_ENABLE      = 32'h00000000;
   localparam logic [31:0] BYTE_TEST_VALUE   = 32'h87654321;

   // event control register fields
   localparam int CTRL_SOFTWARE_IRQ_EN = 0;
   localparam int CTRL_STOP_TRANSMIT   = 1;

   // drop counter midpoint crossing and timer wrap value
   localparam logic [31:0] DROP_BEFORE_MID = 32'h7FFFFFFF;
   localparam logic [31:0] DROP_AFTER_MID  = 32'h80000000;
   localparam logic [15:0] TIMER_WRAP_VAL  = 16'hFFFF;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : eis_pkg

// ### test_eis_interrupt_status.sv
`timescale 1ns/1ps
`default_nettype none

module test_eis_interrupt_status;
   logic aclk, aresetn, woke;
   logic [31:0] ev, dc, rdat;
   logic [15:0] tc;
   logic [1:0]  rsp;
   int failures, checks_done, cyc;
   wire [7:0] awaddr, araddr;
   wire [31:0] wdata, rdata;
   wire [3:0] wstrb;
   wire [1:0] bresp, rresp;
   wire awvalid, awready, wvalid, wready, bvalid, bready;
   wire arvalid, arready, rvalid, rready;
   wire irq_request, power_irq, wake_request, stop_transmit;
   localparam logic [31:0] EV_BITS = 32'h0133EFFF;

   eis_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   eis_interrupt_status dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .tx_halted(ev[25]), .rx_halted(ev[24]), .drop_count(dc),
      .tx_buffer_done(ev[21]), .tx_buffer_notify(ev[21]),
      .rx_dma_done(ev[20]), .timer_count(tc), .phy_event(ev[18]),
      .power_event(ev[17]), .tx_status_ovf(ev[16]),
      .rx_oversize(ev[15]), .rx_error(ev[14]), .tx_error(ev[13]),
      .tx_underrun(ev[11]), .tx_data_full(ev[10]),
      .tx_data_write(ev[10]), .tx_space_above(ev[9]),
      .tx_status_full(ev[8]), .tx_status_level(ev[7]),
      .frame_dropped(ev[6]), .rx_data_level(ev[5]),
      .rx_status_full(ev[4]), .rx_status_level(ev[3]),
      .pin_events(ev[2:0]), .pin_sync_sel({3{ev[12]}}),
      .irq_request(irq_request), .power_irq(power_irq),
      .wake_request(wake_request), .stop_transmit(stop_transmit));

   ////////////////////////////////////////
   // clock, and a hang guard far beyond the under a thousand cycles needed
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   initial {aresetn, woke, ev, dc, tc, cyc} = {34'h0, 32'h0, 16'h5, 32'h0};
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (wake_request === 1'b1) woke <= 1'b1;
      if (cyc == 20000) begin failures++; end_of_test(); end
   end

   task automatic chk(input string n, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin failures++;
         $display("mismatch %s expected %h seen %h", n, e, g); end
   endtask : chk
   task automatic rs(input logic [7:0] a, input logic [31:0] e);
      host.rd(a, rdat, rsp);
      chk("register", e, rdat);
   endtask : rs
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      host.wr(a, d, rsp);
   endtask : w
   // one-cycle event, then time for it to land
   task automatic pulse(input int b);
      ev[b] <= 1'b1;
      @(posedge aclk);
      ev[b] <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask : pulse
   task automatic end_of_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////
   // register sequences
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rs(8'h58, 32'h0);
      rs(8'h64, 32'h87654321);
      host.rd(8'h10, rdat, rsp);
      chk("unmapped resp", 32'h2, {30'h0, rsp});
      for (int b = 0; b < 32; b++) if (EV_BITS[b])
      begin
         pulse(b);
         rs(8'h58, 32'h1 << b);
         chk("irq masked", 32'h0, {31'h0, irq_request});
         w(8'h58, 32'h0);
         rs(8'h58, 32'h1 << b);
         w(8'h58, 32'h1 << b);
         rs(8'h58, 32'h0);
      end
      ev[12] <= 1'b1;
      ev[0] <= 1'b1;
      pulse(1);
      rs(8'h58, 32'h1);
      w(8'h58, 32'h1);
      ev[18] <= 1'b1;
      w(8'h58, 32'h00040000);
      rs(8'h58, 32'h00040000);
      ev[18] <= 1'b0;
      rs(8'h58, 32'h0);
      dc <= 32'h7FFFFFFF;
      rs(8'h58, 32'h0);
      dc <= 32'h80000000;
      tc <= 16'h0000;
      rs(8'h58, 32'h00800000);
      tc <= 16'hFFFF;
      w(8'h58, 32'h00800000);
      rs(8'h58, 32'h00080000);
      w(8'h58, 32'h00080000);
      w(8'hC0, 32'h1);
      rs(8'h58, 32'h80000000);
      ev[25] <= 1'b1;
      w(8'hC0, 32'h0);
      w(8'h58, 32'h80000000);
      rs(8'h58, 32'h0);
      w(8'hC0, 32'h2);
      chk("stop", 32'h1, {31'h0, stop_transmit});
      rs(8'h58, 32'h02000000);
      w(8'h58, 32'h02000000);
      // event lands on the very edge of the clear
      fork
         w(8'h58, 32'h00004000);
         begin
            @(posedge aclk) ev[14] <= 1'b1;
            @(posedge aclk) ev[14] <= 1'b0;
         end
      join
      rs(8'h58, 32'h00004000);
      w(8'h5C, 32'h00020040);
      rs(8'h5C, 32'h00020040);
      pulse(17);
      chk("power irq", 32'h1, {31'h0, power_irq});
      rs(8'hC4, 32'h1);
      chk("woke early", 32'h0, {31'h0, woke});
      w(8'h64, 32'h0);
      @(posedge aclk);
      chk("woke", 32'h1, {31'h0, woke});
      w(8'h58, 32'h00024000);
      repeat (2) @(posedge aclk);
      chk("irq clear", 32'h0, {31'h0, irq_request});
      end_of_test();
   end
endmodule : test_eis_interrupt_status

bind eis_interrupt_status eis_interrupt_status_monitor mon (.aclk(aclk),
   .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .irq_request(irq_request), .power_irq(power_irq),
   .wake_request(wake_request));

`default_nettype wire
